// [logic/ps_channel.sv]
// Purpose: One comparator channel with mode select, hysteresis and a 20 ms history.
// Assumes: cmp.sample pulses once per program cycle with a fresh scaled value.
// Notes:   Change modes stay false until the history has filled once.
`timescale 1ns/1ps
module ps_channel #(
    parameter int VAL_W      = ps_pkg::VAL_W_DEF,
    parameter int HIST_DEPTH = ps_pkg::HIST_DEPTH_DEF
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Settings in, condition out.
    ps_cmp_if.chan    cmp
);
    localparam int PTR_W = (HIST_DEPTH > 1) ? $clog2(HIST_DEPTH) : 1;
    localparam int W2    = 2 * VAL_W;

    typedef struct packed {
        logic [HIST_DEPTH-1:0][VAL_W-1:0] hist;
        logic [PTR_W-1:0]                 ptr;
        logic                             filled;
        logic                             fulfilled;
    } ps_chan_s;

    ps_chan_s          st_reg;
    ps_chan_s          st_next;
    logic signed [VAL_W-1:0] v, pk, refv, d, x, t, band, rel, h_s;
    logic signed [W2-1:0]    prod;
    logic              under, valid, hit, hold, inhibit;

    function automatic logic signed [VAL_W-1:0] absv(input logic signed [VAL_W-1:0] a);
        absv = (a < 0) ? -a : a;
    endfunction

    // Comparison quantity and threshold per mode, then hysteresis latch.
    always_comb
    begin
        st_next = st_reg;
        v       = $signed(cmp.value);
        pk      = $signed(cmp.pickup);
        refv    = $signed(st_reg.hist[st_reg.ptr]);
        d       = v - refv;
        prod    = W2'(absv(refv)) * W2'(pk);
        rel     = VAL_W'(prod / W2'(ps_pkg::PCT_ONE));
        x       = v;
        t       = pk;
        under   = 1'b0;
        valid   = 1'b1;
        case (ps_pkg::ps_mode_e'(cmp.mode))
            ps_pkg::MODE_OVER:          x = v;
            ps_pkg::MODE_OVER_ABS:      x = absv(v);
            ps_pkg::MODE_UNDER:         under = 1'b1;
            ps_pkg::MODE_UNDER_ABS:
            begin
                x     = absv(v);
                under = 1'b1;
            end
            ps_pkg::MODE_DELTA_PCT:
            begin
                x     = d;
                t     = rel;
                under = pk < 0;
                valid = st_reg.filled;
            end
            ps_pkg::MODE_DELTA_PCT_ABS:
            begin
                x     = absv(d);
                t     = absv(rel);
                valid = st_reg.filled;
            end
            ps_pkg::MODE_DELTA_VAL:
            begin
                x     = d;
                under = pk < 0;
                valid = st_reg.filled;
            end
            ps_pkg::MODE_DELTA_VAL_ABS:
            begin
                x     = absv(d);
                t     = absv(pk);
                valid = st_reg.filled;
            end
            default:                    x = v;
        endcase
        h_s     = VAL_W'($signed({1'b0, cmp.hyst}));
        prod    = W2'(absv(t)) * W2'(h_s);
        band    = VAL_W'(prod / W2'(ps_pkg::PCT_ONE));
        hit     = under ? (x < t) : (x > t);
        hold    = under ? (x <= t + band) : (x >= t - band);
        inhibit = (cmp.mode == 3'(ps_pkg::MODE_UNDER) || cmp.mode == 3'(ps_pkg::MODE_UNDER_ABS))
                  && (v < $signed(cmp.block_lim));
        if (!cmp.enable)
            st_next.fulfilled = 1'b0;
        else if (cmp.sample)
        begin
            st_next.fulfilled = valid && !inhibit && (st_reg.fulfilled ? hold : hit);
            st_next.hist[st_reg.ptr] = cmp.value;
            if (st_reg.ptr == PTR_W'(HIST_DEPTH - 1))
            begin
                st_next.ptr    = '0;
                st_next.filled = 1'b1;
            end
            else
                st_next.ptr = st_reg.ptr + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign cmp.fulfilled = st_reg.fulfilled;
endmodule

// [logic/ps_cmp_if.sv]
// Purpose: Carries settings and results between the stage core and one comparator channel.
// Assumes: Settings are static between samples.
// Notes:   Values are signed counts of 0.0001.
`timescale 1ns/1ps
interface ps_cmp_if #(
    parameter int VAL_W  = ps_pkg::VAL_W_DEF,
    parameter int HYST_W = ps_pkg::HYST_W_DEF
);
    logic              enable;
    logic              sample;
    logic [2:0]        mode;
    logic [VAL_W-1:0]  value;
    logic [VAL_W-1:0]  pickup;
    logic [HYST_W-1:0] hyst;
    logic [VAL_W-1:0]  block_lim;
    logic              fulfilled;

    // The core drives settings and samples, the channel answers with its condition.
    modport core (output enable, output sample, output mode, output value, output pickup,
                  output hyst, output block_lim, input fulfilled);
    modport chan (input enable, input sample, input mode, input value, input pickup,
                  input hyst, input block_lim, output fulfilled);
endinterface

// [logic/ps_pkg.sv]
// Purpose: Shared constants and types of the programmable comparator stage.
// Assumes: Values are signed fixed point counts of 0.0001, percentages count 0.0001 %.
// Notes:   Timing counts derived here feed top-level parameters.
package ps_pkg;

    // Fixed point scaling of values, factors and ratios.
    localparam int FRAC_ONE = 10000;
    // One whole fraction expressed in 0.0001 % steps, used by hysteresis and deltas.
    localparam int PCT_ONE = 1000000;

    // Default data widths.
    localparam int VAL_W_DEF  = 40;
    localparam int HYST_W_DEF = 24;
    localparam int TIME_W_DEF = 21;

    // Timing: clock period, one millisecond, change window and program cycle.
    localparam int CLK_PERIOD_NS  = 50;
    localparam int TIME_1MS_NS    = 1000000;
    localparam int MS_CYCLES_DEF  = (TIME_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHANGE_WIN_MS  = 20;
    localparam int PROG_CYCLE_MS  = 5;
    localparam int HIST_DEPTH_DEF = CHANGE_WIN_MS / PROG_CYCLE_MS;

    // Number of comparison channels and of ratio outputs (channels plus calculated).
    localparam int NUM_CH    = 3;
    localparam int NUM_RATIO = NUM_CH + 1;

    // Comparator modes in encoding order; over is code zero and the default.
    typedef enum logic [2:0] {
        MODE_OVER,
        MODE_OVER_ABS,
        MODE_UNDER,
        MODE_UNDER_ABS,
        MODE_DELTA_PCT,
        MODE_DELTA_PCT_ABS,
        MODE_DELTA_VAL,
        MODE_DELTA_VAL_ABS
    } ps_mode_e;

    // Stage condition in reported order.
    typedef enum logic [1:0] {
        COND_NORMAL,
        COND_START,
        COND_TRIP,
        COND_BLOCKED
    } ps_cond_e;

endpackage

// [logic/ps_ratio.sv]
// Purpose: Ratio of a measured value to its pick-up setting in 0.0001 units.
// Assumes: Combinational; the caller registers the result.
// Notes:   A zero pick-up gives a zero ratio instead of a divide fault.
`timescale 1ns/1ps
module ps_ratio #(
    parameter int VAL_W = ps_pkg::VAL_W_DEF
) (
    // Operands.
    input  wire logic [VAL_W-1:0] num,
    input  wire logic [VAL_W-1:0] den,
    // Result.
    output logic      [VAL_W-1:0] ratio
);
    logic signed [2*VAL_W-1:0] num_w;
    logic signed [2*VAL_W-1:0] den_w;

    // Wide operands keep the scaled numerator from overflowing.
    always_comb
    begin
        num_w = (2*VAL_W)'($signed(num)) * (2*VAL_W)'(ps_pkg::FRAC_ONE);
        den_w = (2*VAL_W)'($signed(den));
        if (den_w == '0)
            ratio = '0;
        else
            ratio = VAL_W'(num_w / den_w);
    end
endmodule

// [logic/ps_stage.sv]
// Purpose: Programmable comparator stage: scaling, three comparisons, timing and status.
// Assumes: meas_valid pulses once per program cycle; settings are static inputs.
// Notes:   Values are signed counts of 0.0001; delays and remaining time are in ms.
`timescale 1ns/1ps
module ps_stage #(
    parameter int VAL_W      = ps_pkg::VAL_W_DEF,
    parameter int HYST_W     = ps_pkg::HYST_W_DEF,
    parameter int TIME_W     = ps_pkg::TIME_W_DEF,
    parameter int HIST_DEPTH = ps_pkg::HIST_DEPTH_DEF,
    parameter int MS_CYCLES  = ps_pkg::MS_CYCLES_DEF
) (
    // Clock and reset.
    input  wire logic                                  core_clk,
    input  wire logic                                  arst_n,
    // Measurements from the measurement subsystem.
    input  wire logic                                  meas_valid,
    input  wire logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0]  meas_raw,
    input  wire logic [VAL_W-1:0]                      calc_value,
    input  wire logic [VAL_W-1:0]                      calc_pickup,
    // Measurement count and per channel settings.
    input  wire logic [1:0]                            meas_count,
    input  wire logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0]  input_scale_factor,
    input  wire logic [ps_pkg::NUM_CH-1:0][2:0]        comparator_mode_select,
    input  wire logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0]  pickup_level,
    input  wire logic [ps_pkg::NUM_CH-1:0][HYST_W-1:0] reset_hysteresis_pct,
    input  wire logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0]  block_limit,
    // Stage timing settings in milliseconds.
    input  wire logic [TIME_W-1:0]                     op_delay_ms,
    input  wire logic [TIME_W-1:0]                     release_delay_ms,
    // Blocking matrix input.
    input  wire logic                                  block_in,
    // Stage outputs.
    output logic                                       start_out,
    output logic                                       trip_out,
    output logic                                       blocked_out,
    output logic [1:0]                                 condition,
    output logic [TIME_W-1:0]                          time_to_trip_ms,
    // Read-only values.
    output logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0]       scaled_value,
    output logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0]       ratio_value,
    output logic [VAL_W-1:0]                           calc_ratio
);
    localparam int MS_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam int W2   = 2 * VAL_W;

    typedef struct packed {
        logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0] scaled;
        logic [ps_pkg::NUM_CH-1:0][VAL_W-1:0] ratio;
        logic [VAL_W-1:0]                     calc_ratio;
        logic                                 sample;
        ps_pkg::ps_cond_e                     state;
        logic                                 releasing;
        logic [TIME_W-1:0]                    op_cnt;
        logic [TIME_W-1:0]                    rel_cnt;
        logic [MS_W-1:0]                      ms_cnt;
        logic                                 start;
        logic                                 trip;
        logic                                 blocked;
        logic [TIME_W-1:0]                    remaining;
    } ps_stage_s;

    ps_stage_s                           st_reg;
    ps_stage_s                           st_next;
    logic [ps_pkg::NUM_CH-1:0]           fulfilled;
    logic [ps_pkg::NUM_CH-1:0]           enabled;
    logic [ps_pkg::NUM_RATIO-1:0][VAL_W-1:0] ratio_num;
    logic [ps_pkg::NUM_RATIO-1:0][VAL_W-1:0] ratio_den;
    logic [ps_pkg::NUM_RATIO-1:0][VAL_W-1:0] ratio_res;
    logic [1:0]                          eff_count;
    logic                                pickup;
    logic                                ms_tick;
    logic signed [W2-1:0]                prod;

    // A zero count still follows one measurement, so the stage never sits idle by mistake.
    always_comb
    begin
        eff_count = (meas_count == 2'h0) ? 2'h1 : meas_count;
        for (int i = 0; i < ps_pkg::NUM_CH; i++)
            enabled[i] = (2'(i) < eff_count);
    end

    // Pick-up needs every followed comparison fulfilled at once.
    assign pickup = &(fulfilled | ~enabled);

    // One millisecond prescaler; it restarts whenever a delay is loaded.
    assign ms_tick = (st_reg.ms_cnt == MS_W'(MS_CYCLES - 1));

    // Comparator channels, one per possible measurement.
    for (genvar g = 0; g < ps_pkg::NUM_CH; g++)
    begin : g_ch
        ps_cmp_if #(.VAL_W(VAL_W), .HYST_W(HYST_W)) cmp_bus ();

        assign cmp_bus.enable    = enabled[g];
        assign cmp_bus.sample    = st_reg.sample;
        assign cmp_bus.mode      = comparator_mode_select[g];
        assign cmp_bus.value     = st_reg.scaled[g];
        assign cmp_bus.pickup    = pickup_level[g];
        assign cmp_bus.hyst      = reset_hysteresis_pct[g];
        assign cmp_bus.block_lim = block_limit[g];
        assign fulfilled[g]      = cmp_bus.fulfilled;

        ps_channel #(
            .VAL_W      (VAL_W),
            .HIST_DEPTH (HIST_DEPTH)
        ) u_channel (
            .core_clk (core_clk),
            .arst_n   (arst_n),
            .cmp      (cmp_bus.chan)
        );
    end

    // Ratio operands: each scaled value, plus the calculated magnitude last.
    always_comb
    begin
        for (int i = 0; i < ps_pkg::NUM_CH; i++)
        begin
            ratio_num[i] = st_reg.scaled[i];
            ratio_den[i] = pickup_level[i];
        end
        ratio_num[ps_pkg::NUM_CH] = calc_value;
        ratio_den[ps_pkg::NUM_CH] = calc_pickup;
    end

    // Ratio dividers are combinational; their results are registered in the state.
    for (genvar r = 0; r < ps_pkg::NUM_RATIO; r++)
    begin : g_ratio
        ps_ratio #(
            .VAL_W (VAL_W)
        ) u_ratio (
            .num   (ratio_num[r]),
            .den   (ratio_den[r]),
            .ratio (ratio_res[r])
        );
    end

    // Scaling, condition sequencing and timers.
    always_comb
    begin
        st_next        = st_reg;
        prod           = '0;
        st_next.sample = meas_valid;
        st_next.ms_cnt = ms_tick ? '0 : st_reg.ms_cnt + 1'b1;

        // Scaled values change once per program cycle; a factor of one passes them unchanged.
        if (meas_valid)
        begin
            for (int i = 0; i < ps_pkg::NUM_CH; i++)
            begin
                prod = W2'($signed(meas_raw[i])) * W2'($signed(input_scale_factor[i]));
                st_next.scaled[i] = VAL_W'(prod / W2'(ps_pkg::FRAC_ONE));
            end
        end

        // Ratios follow the inputs continuously.
        for (int i = 0; i < ps_pkg::NUM_CH; i++)
            st_next.ratio[i] = ratio_res[i];
        st_next.calc_ratio = ratio_res[ps_pkg::NUM_CH];

        // The blocking input is looked at every clock, so a block that arrives ahead of
        // the delay end by far less than the margin the source owes still takes effect.
        case (st_reg.state)
            ps_pkg::COND_NORMAL:
            begin
                if (pickup && block_in)
                    st_next.state = ps_pkg::COND_BLOCKED;
                else if (pickup)
                begin
                    st_next.state     = ps_pkg::COND_START;
                    st_next.releasing = 1'b0;
                    st_next.op_cnt    = op_delay_ms;
                    st_next.ms_cnt    = '0;
                end
            end
            ps_pkg::COND_START:
            begin
                if (pickup && !block_in)
                begin
                    // Operate timing runs; a release in progress is cancelled.
                    if (st_reg.releasing)
                    begin
                        st_next.releasing = 1'b0;
                        st_next.op_cnt    = op_delay_ms;
                        st_next.ms_cnt    = '0;
                    end
                    else if (st_reg.op_cnt == '0)
                        st_next.state = ps_pkg::COND_TRIP;
                    else if (ms_tick)
                        st_next.op_cnt = st_reg.op_cnt - 1'b1;
                end
                else if (!st_reg.releasing)
                begin
                    // Clearing pick-up and a late block both start release timing.
                    st_next.releasing = 1'b1;
                    st_next.rel_cnt   = release_delay_ms;
                    st_next.ms_cnt    = '0;
                end
                else if (st_reg.rel_cnt == '0)
                begin
                    st_next.state     = ps_pkg::COND_NORMAL;
                    st_next.releasing = 1'b0;
                end
                else if (ms_tick)
                    st_next.rel_cnt = st_reg.rel_cnt - 1'b1;
            end
            ps_pkg::COND_TRIP:
            begin
                // Trip drops at once; start is then held for the release delay.
                if (!pickup || block_in)
                begin
                    st_next.state     = ps_pkg::COND_START;
                    st_next.releasing = 1'b1;
                    st_next.rel_cnt   = release_delay_ms;
                    st_next.ms_cnt    = '0;
                end
            end
            ps_pkg::COND_BLOCKED:
            begin
                // Leaving through normal lets a fresh pick-up be judged again.
                if (!pickup || !block_in)
                    st_next.state = ps_pkg::COND_NORMAL;
            end
            default:
                st_next.state = ps_pkg::COND_NORMAL;
        endcase

        // Outputs are decoded from the next state so that they leave flip-flops.
        st_next.start   = (st_next.state == ps_pkg::COND_START) ||
                          (st_next.state == ps_pkg::COND_TRIP);
        st_next.trip    = (st_next.state == ps_pkg::COND_TRIP);
        st_next.blocked = (st_next.state == ps_pkg::COND_BLOCKED);
        if (st_next.state == ps_pkg::COND_START && !st_next.releasing)
            st_next.remaining = st_next.op_cnt;
        else
            st_next.remaining = '0;
    end

    // State register.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // Every output is a field of the registered state.
    assign start_out       = st_reg.start;
    assign trip_out        = st_reg.trip;
    assign blocked_out     = st_reg.blocked;
    assign condition       = st_reg.state;
    assign time_to_trip_ms = st_reg.remaining;
    assign scaled_value    = st_reg.scaled;
    assign ratio_value     = st_reg.ratio;
    assign calc_ratio      = st_reg.calc_ratio;
endmodule

// [sim/ps_meas_src.sv]
// Purpose: Measurement source model that hands the stage one sample per request.
// Assumes: req is a one-cycle pulse raised by the bench after a clock edge.
// Notes:   Outside the valid cycle the raw bus carries inverted data.
`timescale 1ns/1ps
module ps_meas_src #(
    parameter int VAL_W = 40
) (
    // Clock and request from the bench.
    input  wire logic                  core_clk,
    input  wire logic                  req,
    input  wire logic [2:0][VAL_W-1:0] raw_in,
    // Towards the stage.
    output logic                       meas_valid,
    output logic      [2:0][VAL_W-1:0] meas_raw
);
    // Scrambling the bus between samples exposes any read of stale data.
    always @(posedge core_clk)
    begin
        meas_valid <= req;
        meas_raw   <= req ? raw_in : ~raw_in;
    end
endmodule

// [sim/ps_stage_assertions.sv]
// Purpose: Port level checks of the programmable comparator stage.
// Assumes: One clock domain with an active low asynchronous reset.
// Notes:   Timing relations are checked against the live delay setting.
`timescale 1ns/1ps
module ps_stage_chk #(
    parameter int VAL_W  = 40,
    parameter int TIME_W = 21
) (
    // Clock, reset and watched inputs.
    input wire logic                  core_clk,
    input wire logic                  arst_n,
    input wire logic                  meas_valid,
    input wire logic [2:0][VAL_W-1:0] meas_raw,
    input wire logic [2:0][VAL_W-1:0] input_scale_factor,
    input wire logic                  block_in,
    input wire logic [TIME_W-1:0]     op_delay_ms,
    // Watched outputs.
    input wire logic                  start_out,
    input wire logic                  trip_out,
    input wire logic                  blocked_out,
    input wire logic [1:0]            condition,
    input wire logic [TIME_W-1:0]     time_to_trip_ms,
    input wire logic [2:0][VAL_W-1:0] scaled_value
);
    // All checks share the stage clock and reset.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    cond_normal_a: assert property (condition == 2'h0 |-> !start_out && !blocked_out)
        else $error("normal with outputs");
    start_map_a: assert property (start_out == (condition inside {2'h1, 2'h2}))
        else $error("start and condition differ");
    blk_excl_a: assert property (blocked_out |-> !start_out && condition == 2'h3)
        else $error("blocked with start");
    ttt_load_a: assert property ($rose(start_out) |-> time_to_trip_ms == op_delay_ms)
        else $error("remaining time not loaded");
    ttt_down_a: assert property (start_out && time_to_trip_ms != 0
        |=> time_to_trip_ms <= $past(time_to_trip_ms)) else $error("remaining time rose");
    trip_after_a: assert property ($rose(trip_out) |-> $past(time_to_trip_ms) == 0)
        else $error("trip before delay");
    blk_trip_a: assert property (block_in && trip_out |=> !trip_out)
        else $error("trip kept under block");
    scale_unit_a: assert property ($past(meas_valid) && $past(input_scale_factor[0]) == 10000
        |-> scaled_value[0] == $past(meas_raw[0])) else $error("unit factor changed value");
endmodule
bind ps_stage ps_stage_chk #(.VAL_W(VAL_W), .TIME_W(TIME_W)) i_chk (
    .core_clk(core_clk), .arst_n(arst_n), .meas_valid(meas_valid), .meas_raw(meas_raw),
    .input_scale_factor(input_scale_factor), .block_in(block_in), .op_delay_ms(op_delay_ms),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .condition(condition), .time_to_trip_ms(time_to_trip_ms), .scaled_value(scaled_value));

// [sim/tb_top.sv]
// Purpose: Self-checking bench of the programmable comparator stage.
// Assumes: One millisecond is shortened to four clock cycles.
// Notes:   Scaled values are checked from a queue of notes.
`timescale 1ns/1ps
module tb_top;
    localparam int VW = 40;
    localparam logic [4:0] NRM = 5'h00, STA = 5'h11, TRP = 5'h1A, BLK = 5'h07;
    localparam longint MB[8] = '{0, 0, 60000, 60000, 100000, 100000, 0, 0};
    localparam longint MX[8] = '{60000, -60000, 20000, -20000, 110000, 90000, 60000, -60000};
    logic               core_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               req = 1'b0;
    logic               block_in = 1'b0;
    logic [1:0]         cnt = 2'h3;
    logic [2:0][VW-1:0] raw = '0, fac = {3{40'h2710}}, pick = {3{40'h7FFFFFFFFF}}, blim = '0;
    logic [2:0][2:0]    mode = '0;
    logic [2:0][VW-1:0] mraw, scaled, ratio;
    logic               mv, start_out, trip_out, blocked_out;
    logic [1:0]         cond;
    logic [20:0]        ttt;
    logic [VW-1:0]      cratio;
    logic [VW-1:0]      exp_q[$];
    int                 bad_count = 0;
    int                 tests_run = 0;
    wire  [4:0]         st = {start_out, trip_out, blocked_out, cond};
    // Free running 20 MHz clock.
    always #25 core_clk = ~core_clk;
    ps_meas_src #(.VAL_W(VW)) i_src (.core_clk(core_clk), .req(req), .raw_in(raw),
        .meas_valid(mv), .meas_raw(mraw));
    ps_stage #(.MS_CYCLES(4)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .meas_valid(mv),
        .meas_raw(mraw), .calc_value(40'h9C40), .calc_pickup(40'h4E20), .meas_count(cnt),
        .input_scale_factor(fac), .comparator_mode_select(mode), .pickup_level(pick),
        .reset_hysteresis_pct({3{24'h007530}}), .block_limit(blim), .op_delay_ms(21'h3),
        .release_delay_ms(21'h2), .block_in(block_in), .start_out(start_out),
        .trip_out(trip_out), .blocked_out(blocked_out), .condition(cond),
        .time_to_trip_ms(ttt), .scaled_value(scaled), .ratio_value(ratio), .calc_ratio(cratio));
    task automatic chk(input logic [VW-1:0] e, input logic [VW-1:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_st(input logic [4:0] e, input int n);
        repeat (n) if (st !== e) cyc(1);
        chk(VW'(e), VW'(st));
    endtask
    // Each request notes the scaled result of all three channels.
    task automatic sample(input longint v);
        longint e;
        raw[0] = VW'(v);
        for (int i = 0; i < 3; i++)
        begin
            e = longint'($signed(raw[i])) * longint'($signed(fac[i])) / 10000;
            exp_q.push_back(VW'(e));
        end
        req = 1'b1;
        cyc(1);
        req = 1'b0;
    endtask
    task automatic rst();
        arst_n = 1'b0;
        cyc(2);
        chk(VW'(NRM), VW'(st));
        arst_n = 1'b1;
        cyc(1);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Scaled values are taken the edge after the sample is seen.
    always @(posedge core_clk)
        if (mv === 1'b1)
        begin
            @(negedge core_clk);
            for (int i = 0; i < 3; i++) chk(exp_q.pop_front(), scaled[i]);
        end
    // A hang is cut short well beyond the expected run of some 300 cycles.
    initial
    begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
    // Main sequence.
    initial
    begin
        void'($urandom(32'h4A8EA84F));
        cyc(12);
        arst_n = 1'b1;
        cyc(1);
        for (int k = 0; k < 6; k++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                fac[i] = (k == 0) ? 40'h2710 : VW'($urandom_range(20000));
                raw[i] = VW'(longint'($urandom_range(1 << 20)) - (1 << 19));
            end
            sample($signed(raw[0]));
            cyc(4);
        end
        chk(VW'(NRM), VW'(st));
        $display("done scaling");
        cnt = 2'h1;
        fac = {3{40'h2710}};
        pick[0] = 40'h186A0;
        sample(110000);
        wait_st(STA, 8);
        chk(40'h3, VW'(ttt));
        chk(40'h2AF8, ratio[0]);
        chk(40'h4E20, cratio);
        cyc(9);
        chk(VW'(STA), VW'(st));
        wait_st(TRP, 8);
        sample(98000);
        cyc(6);
        chk(VW'(TRP), VW'(st));
        block_in = 1'b1;
        cyc(1);
        block_in = 1'b0;
        chk(VW'(STA), VW'(st));
        sample(96000);
        cyc(6);
        chk(VW'(STA), VW'(st));
        wait_st(NRM, 14);
        $display("done timing");
        block_in = 1'b1;
        sample(120000);
        wait_st(BLK, 8);
        block_in = 1'b0;
        wait_st(STA, 6);
        block_in = 1'b1;
        cyc(2);
        chk(40'h0, VW'(ttt));
        wait_st(BLK, 20);
        $display("done blocking");
        pick[0] = 40'hC350;
        blim[0] = -40'sd100000;
        for (int m = 0; m < 8; m++)
        begin
            rst();
            block_in = 1'b0;
            mode[0] = 3'(m);
            repeat (4)
            begin
                sample(MB[m]);
                cyc(1);
            end
            cyc(4);
            chk(VW'(NRM), VW'(st));
            sample(MX[m]);
            wait_st(STA, 8);
        end
        $display("done modes");
        rst();
        mode[0] = 3'h2;
        blim[0] = 40'h2710;
        sample(5000);
        cyc(6);
        chk(VW'(NRM), VW'(st));
        sample(20000);
        wait_st(STA, 8);
        cnt = 2'h2;
        wait_st(NRM, 16);
        cnt = 2'h0;
        wait_st(STA, 8);
        $display("done limit");
        wrap_up();
    end
endmodule
